// ### shared/epe_pkg.sv
// What this block does
// - erased reads one; program only clears bits
// - program/erase only valid, unprotected targets
// - latch_mode captures only valid array or config byte writes
// - later valid write replaces captured pair
// - array reads return latch data while latching
// - control writes ignored until pair captured
// - hv_enable refused without latch and capture
// - hv_enable switches pump and voltage
// - clearing both bits clears hv_enable only
// - erase mode frozen while hv_enable set
// - block/bulk erase never touch config byte
// - protected blocks and bulk erase inhibited
// - four 128-byte blocks with protect bits
// - no voltage for protected targets
// - reset copies config byte to volatile copy
// - config byte read reloads volatile copy
// - security arms: secure range, config frozen
// - armed: block, bulk, config erase disabled
// - armed: secure writes are not valid writes
// - mode decode 00/01/10/11, reset clears
// - latch_mode cannot clear while hv set
// - stop removes voltage, hv_enable kept
package epe_pkg;

   localparam int ADDR_W = 16;
   localparam int IDX_W = 11;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] ARR_LO_IDX = 11'h600;
   localparam logic [IDX_W-1:0] ARR_HI_IDX = 11'h7FF;
   localparam logic [IDX_W-1:0] SEC_LO_IDX = 11'h7F0;
   localparam logic [IDX_W-1:0] CTRL_IDX = 11'h040;
   localparam logic [IDX_W-1:0] NV_IDX = 11'h041;
   localparam logic [IDX_W-1:0] VOL_IDX = 11'h042;

   localparam int ARR_DEPTH = 512;
   localparam int BLK_LSB = 7;
   localparam int NV_SEC_BIT = 4;
   localparam logic [7:0] NV_FACTORY = 8'h10;
   localparam logic [7:0] ERASED = 8'hFF;

   localparam int CTRL_CAPT_BIT = 4;
   localparam int CTRL_HVON_BIT = 5;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_PROGRAM = 2'b00,
      MODE_BYTE_ERASE = 2'b01,
      MODE_BLOCK_ERASE = 2'b10,
      MODE_BULK_ERASE = 2'b11
   } epe_mode_t;

   typedef enum logic [2:0] {
      TGT_NONE = 3'b000,
      TGT_ARRAY = 3'b001,
      TGT_CTRL = 3'b010,
      TGT_NV = 3'b011,
      TGT_VOL = 3'b100
   } epe_tgt_t;

   typedef struct packed {
      epe_mode_t mode;
      logic latch_mode;
      logic hv_enable;
   } epe_ctrl_t;

endpackage

// ### logic/epe_ctrl.sv
`timescale 1ns/10ps
module epe_ctrl
   import epe_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic stop_mode,
   output logic hv_applied,
   output logic [7:0] array_config
);

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic epe_tgt_t tgt_of(input logic [IDX_W-1:0] idx);
      epe_tgt_t t;
      t = TGT_NONE;
      if (idx >= ARR_LO_IDX && idx <= ARR_HI_IDX)
         t = TGT_ARRAY;
      else if (idx == CTRL_IDX)
         t = TGT_CTRL;
      else if (idx == NV_IDX)
         t = TGT_NV;
      else if (idx == VOL_IDX)
         t = TGT_VOL;
      return t;
   endfunction

   function automatic logic in_secure(input logic [IDX_W-1:0] idx);
      return idx >= SEC_LO_IDX && idx <= ARR_HI_IDX;
   endfunction

   function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
      return a[IDX_W+1:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic aw_have_r;
   logic w_have_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [7:0] wbyte_r;
   logic wlane_r;
   logic awready_r;
   logic wready_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic arready_r;
   logic rd_pend_r;
   logic [ADDR_W-1:0] araddr_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;

   epe_ctrl_t ctrl_r;
   logic captured_r;
   logic [IDX_W-1:0] lat_idx_r;
   logic lat_nv_r;
   logic [7:0] lat_data_r;
   logic hv_on_r;
   logic op_done_r;
   logic [7:0] vol_r;
   logic [7:0] nv_r = NV_FACTORY;
   logic [7:0] mem [0:ARR_DEPTH-1] = '{default: ERASED};

   logic wr_fire;
   logic wr_en;
   logic [IDX_W-1:0] wr_idx;
   epe_tgt_t wr_tgt;
   logic armed;
   logic wr_valid_target;
   logic ctrl_locked;
   epe_ctrl_t wctrl;
   logic [IDX_W-1:0] rd_idx;
   epe_tgt_t rd_tgt;
   logic op_ok;
   logic [1:0] lat_blk;
   logic [8:0] lat_off;

   // nonvolatile contents: no reset branch reaches the cells or the config
   // byte, so a system reset keeps programmed data, protection and the
   // security state; the power-up values model a part fresh from the
   // factory, all cells erased and security not armed

   assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
   assign wr_en = wr_fire & wlane_r;
   assign wr_idx = idx_of(awaddr_r);
   assign wr_tgt = tgt_of(wr_idx);
   assign rd_idx = idx_of(araddr_r);
   assign rd_tgt = tgt_of(rd_idx);
   assign armed = ~nv_r[NV_SEC_BIT];
   assign wctrl = epe_ctrl_t'(wbyte_r[3:0]);
   assign ctrl_locked = ctrl_r.latch_mode & ~captured_r;
   assign lat_off = 9'(lat_idx_r - ARR_LO_IDX);
   assign lat_blk = lat_off[8:BLK_LSB];

   // secured bytes no longer count as valid once armed; config byte frozen too
   assign wr_valid_target = (wr_tgt == TGT_ARRAY && !(armed && in_secure(wr_idx)))
                          | (wr_tgt == TGT_NV && !armed);

   ////////////////////////////////////////////////////////////////////////////
   // target qualification

   // protection follows the volatile copy, so new protect bits wait for a config read
   always_comb
   begin
      op_ok = 1'b0;
      if (captured_r)
      begin
         if (lat_nv_r)
            op_ok = !armed && (ctrl_r.mode == MODE_PROGRAM || ctrl_r.mode == MODE_BYTE_ERASE);
         else
         begin
            case (ctrl_r.mode)
               MODE_PROGRAM, MODE_BYTE_ERASE:
                  op_ok = !vol_r[lat_blk] && !(armed && in_secure(lat_idx_r));
               MODE_BLOCK_ERASE:
                  op_ok = !vol_r[lat_blk] && !armed;
               MODE_BULK_ERASE:
                  op_ok = (vol_r[3:0] == 4'h0) && !armed;
               default:
                  op_ok = 1'b0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel: one write at a time, ready drops until b taken

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= '0;
         wbyte_r <= 8'h00;
         wlane_r <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && awready_r)
         begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            awready_r <= 1'b0;
         end
         if (s_axi_wvalid && wready_r)
         begin
            w_have_r <= 1'b1;
            wbyte_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
            wready_r <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bvalid_r <= 1'b1;
            // unmapped targets answer with an error and change nothing
            bresp_r <= (wr_tgt == TGT_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
         if (bvalid_r && s_axi_bready)
         begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel: data one cycle after the address is taken

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         arready_r <= 1'b1;
         rd_pend_r <= 1'b0;
         araddr_r <= '0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_arvalid && arready_r)
         begin
            araddr_r <= s_axi_araddr;
            arready_r <= 1'b0;
            rd_pend_r <= 1'b1;
         end
         if (rd_pend_r)
         begin
            rd_pend_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            case (rd_tgt)
               // latched data hides the cell contents until latch_mode clears
               TGT_ARRAY:
                  rdata_r[7:0] <= ctrl_r.latch_mode ? lat_data_r : mem[9'(rd_idx - ARR_LO_IDX)];
               TGT_CTRL:
               begin
                  rdata_r[3:0] <= ctrl_r;
                  rdata_r[CTRL_CAPT_BIT] <= captured_r;
                  rdata_r[CTRL_HVON_BIT] <= hv_on_r;
               end
               TGT_NV:
                  rdata_r[7:0] <= nv_r;
               TGT_VOL:
                  rdata_r[7:0] <= vol_r;
               default:
                  rresp_r <= RESP_SLVERR;
            endcase
         end
         if (rvalid_r && s_axi_rready)
         begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program/erase control and address/data latch

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         ctrl_r <= '0;
         captured_r <= 1'b0;
         lat_idx_r <= ARR_LO_IDX;
         lat_nv_r <= 1'b0;
         lat_data_r <= 8'h00;
      end
      else if (wr_en)
      begin
         if (wr_tgt == TGT_CTRL && !ctrl_locked)
         begin
            // voltage only with latch set and a captured pair
            ctrl_r.hv_enable <= wctrl.hv_enable
                                & (ctrl_r.hv_enable | (ctrl_r.latch_mode & captured_r));
            // latch held while hv set, including the combined clear
            ctrl_r.latch_mode <= wctrl.latch_mode | ctrl_r.hv_enable;
            if (!ctrl_r.hv_enable)
               ctrl_r.mode <= wctrl.mode;
            if (!wctrl.latch_mode && !ctrl_r.hv_enable)
               captured_r <= 1'b0;
         end
         else if (ctrl_r.latch_mode && wr_valid_target)
         begin
            captured_r <= 1'b1;
            lat_idx_r <= wr_idx;
            lat_nv_r <= (wr_tgt == TGT_NV);
            lat_data_r <= wbyte_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // high voltage gate; duration is software's hv_enable window, cut while stop_mode is high

   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         hv_on_r <= 1'b0;
         op_done_r <= 1'b0;
      end
      else
      begin
         // stop only gates the pump; hv_enable stays set so the window resumes on wake
         hv_on_r <= ctrl_r.hv_enable & ~stop_mode & op_ok;
         if (!ctrl_r.hv_enable)
            op_done_r <= 1'b0;
         else if (hv_on_r)
            op_done_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cell array and config byte; the effect lands once per voltage window

   always_ff @(posedge clk_sys)
   begin
      // a pulse cut by stop is not applied again: the effect is modelled as instant
      if (hv_on_r && !op_done_r)
      begin
         if (lat_nv_r)
            nv_r <= (ctrl_r.mode == MODE_PROGRAM) ? (nv_r & lat_data_r) : ERASED;
         else
         begin
            case (ctrl_r.mode)
               MODE_PROGRAM:
                  mem[lat_off] <= mem[lat_off] & lat_data_r;
               MODE_BYTE_ERASE:
                  mem[lat_off] <= ERASED;
               MODE_BLOCK_ERASE:
                  for (int i = 0; i < ARR_DEPTH; i++)
                  begin
                     if (i[8:BLK_LSB] == lat_blk)
                        mem[i] <= ERASED;
                  end
               default:
                  for (int i = 0; i < ARR_DEPTH; i++)
                  begin
                     mem[i] <= ERASED;
                  end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // volatile array configuration

   always_ff @(posedge clk_sys)
   begin
      if (reset)
         vol_r <= nv_r;
      else if (rd_pend_r && rd_tgt == TGT_NV)
         vol_r <= nv_r;
      else if (wr_en && wr_tgt == TGT_VOL)
         vol_r <= wbyte_r;
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign hv_applied = hv_on_r;
   assign array_config = vol_r;

endmodule

// ### testbench/epe_ctrl_monitor.sv
`timescale 1ns/10ps
module epe_ctrl_monitor
   import epe_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic stop_mode,
   input wire logic hv_applied
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
////////////////////////////////////////////////////////////////////////////////
   chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("write address taken twice");
   chk_ar_latency: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready && !s_axi_rvalid ##1 s_axi_rvalid)
      else $error("read answer late");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write not closed");
   chk_rd_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read lanes not zero");
   chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
      else $error("error read carries data");
   chk_stop_off: assert property (stop_mode |=> !hv_applied)
      else $error("voltage on in stop");
   chk_hv_rise: assert property ($rose(hv_applied) |-> !$past(stop_mode))
      else $error("voltage rose during stop");
   // reset must be checked while reset is high, so the default disable is overridden
   chk_reset_idle: assert property (disable iff (1'b0) reset |=> !hv_applied && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs active after reset");
   cover property ($rose(hv_applied));
   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
   cover property ($fell(hv_applied) && stop_mode);
endmodule
bind epe_ctrl epe_ctrl_monitor i_mon (.clk_sys(clk_sys), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .stop_mode(stop_mode), .hv_applied(hv_applied));

// ### testbench/tb_eeprom_program_erase_control.sv
`timescale 1ns/10ps
module tb_eeprom_program_erase_control
   import epe_pkg::*;
;
   localparam logic [15:0] CA = {3'h0, CTRL_IDX, 2'h0};
   localparam logic [15:0] NA = {3'h0, NV_IDX, 2'h0};
   localparam logic [15:0] VA = {3'h0, VOL_IDX, 2'h0};
   localparam logic [15:0] A0 = {3'h0, ARR_LO_IDX, 2'h0};
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [15:0] awaddr = 16'h0000;
   logic [15:0] araddr = 16'h0000;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic stop_mode = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, hv_applied;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] array_config;
   int miscompares = 0;
   int n_checks = 0;

   epe_ctrl i_dut (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .stop_mode(stop_mode), .hv_applied(hv_applied), .array_config(array_config));

   initial
   begin
      forever #12.5 clk_sys = ~clk_sys;
   end
////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (miscompares == 0 && n_checks > 0)
      begin
         $display("[ PASS ]");
      end
      else
      begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // an edge passes first so no strobe is assigned twice in one step
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      int t;
      t = 0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         t++;
      end while (!bvalid && t < 60);
      if (!bvalid)
      begin
         miscompares++;
         $display("ERROR %0t write response timeout", $time);
      end
      bready <= 1'b0;
      ck(bresp, RESP_OKAY);
   endtask

   task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int t;
      t = 0;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
         t++;
      end while (!rvalid && t < 60);
      if (!rvalid)
      begin
         miscompares++;
         $display("ERROR %0t read response timeout", $time);
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic rc(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      ck(d, exp);
      ck(r, RESP_OKAY);
   endtask

   task automatic op(input epe_mode_t m, input logic [15:0] a, input logic [7:0] d, input logic hv_exp);
      wr(CA, {4'h0, m, 2'b10});
      wr(a, d);
      wr(CA, {4'h0, m, 2'b11});
      repeat (2) @(posedge clk_sys);
      ck(hv_applied, hv_exp);
      wr(CA, 8'h00);
      rc(CA, {26'h0, 2'b01, m, 2'b10});
      wr(CA, 8'h00);
   endtask
////////////////////////////////////////////////////////////////////////////////
   task automatic s_latch();
      ck(array_config, NV_FACTORY);
      wr(CA, 8'h02);
      wr(CA, 8'h03);
      rc(CA, 32'h00000002);
      wr(A0 + 16'h0004, 8'h5A);
      wr(A0 + 16'h0008, 8'h3C);
      rc(A0, 32'h0000003C);
      wr(CA, 8'h03);
      stop_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ck(hv_applied, 1'b0);
      stop_mode <= 1'b0;
      repeat (3) @(posedge clk_sys);
      ck(hv_applied, 1'b1);
      wr(CA, 8'h05);
      rc(CA, 32'h00000033);
      wr(CA, 8'h00);
      rc(CA, 32'h00000012);
      wr(CA, 8'h00);
      rc(A0 + 16'h0008, 32'h0000003C);
      rc(A0 + 16'h0004, 32'h000000FF);
   endtask

   task automatic s_modes();
      logic [31:0] d;
      logic [1:0] r;
      op(MODE_PROGRAM, A0 + 16'h0008, 8'hC3, 1'b1);
      rc(A0 + 16'h0008, 32'h00000000);
      op(MODE_BYTE_ERASE, A0 + 16'h0008, 8'h00, 1'b1);
      rc(A0 + 16'h0008, 32'h000000FF);
      op(MODE_PROGRAM, A0, 8'h00, 1'b1);
      op(MODE_PROGRAM, A0 + 16'h0200, 8'h00, 1'b1);
      op(MODE_BLOCK_ERASE, A0 + 16'h01FC, 8'h00, 1'b1);
      rc(A0, 32'h000000FF);
      rc(A0 + 16'h0200, 32'h00000000);
      op(MODE_BULK_ERASE, A0 + 16'h0200, 8'h00, 1'b1);
      rc(A0 + 16'h0200, 32'h000000FF);
      wr(VA, 8'h0F);
      rc(VA, 32'h0000000F);
      ck(array_config, 8'h0F);
      rc(NA, {24'h0, NV_FACTORY});
      ck(array_config, NV_FACTORY);
      rd(16'h0000, d, r);
      ck(d, 32'h00000000);
      ck(r, RESP_SLVERR);
   endtask

   task automatic s_protect();
      op(MODE_BYTE_ERASE, NA, 8'h00, 1'b1);
      ck(array_config, NV_FACTORY);
      rc(NA, 32'h000000FF);
      repeat (2) @(posedge clk_sys);
      ck(array_config, 8'hFF);
      op(MODE_PROGRAM, A0 + 16'h0400, 8'h00, 1'b0);
      rc(A0 + 16'h0400, 32'h000000FF);
      op(MODE_BULK_ERASE, A0, 8'h00, 1'b0);
      op(MODE_PROGRAM, NA, 8'hF0, 1'b1);
      rc(NA, 32'h000000F0);
      repeat (2) @(posedge clk_sys);
      ck(array_config, 8'hF0);
   endtask

   task automatic s_secure();
      op(MODE_PROGRAM, NA, 8'hE0, 1'b1);
      rc(NA, 32'h000000E0);
      op(MODE_BYTE_ERASE, A0, 8'h00, 1'b1);
      op(MODE_BULK_ERASE, A0, 8'h00, 1'b0);
      // armed: neither the config byte nor a secured byte is latched
      wr(CA, 8'h02);
      wr(NA, 8'h00);
      wr(A0 + 16'h07C0, 8'h00);
      wr(CA, 8'h03);
      repeat (2) @(posedge clk_sys);
      ck(hv_applied, 1'b0);
      rc(CA, 32'h00000002);
      wr(A0 + 16'h0004, 8'h00);
      wr(CA, 8'h00);
      rc(CA, 32'h00000000);
      rc(NA, 32'h000000E0);
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      s_latch();
      s_modes();
      s_protect();
      s_secure();
      stop_test();
   end

   // whole run needs a few hundred cycles; this bound only cuts a hang
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      stop_test();
   end
endmodule
